// ### core/uss_pkg.sv
package uss_pkg;

    // Byte addresses of the register words on the Avalon-MM slave.
    localparam logic [3:0] USS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] USS_ADDR_STAT = 4'h4;
    localparam logic [3:0] USS_ADDR_DEV = 4'h8;
    localparam logic [3:0] USS_ADDR_IEN = 4'hC;

    // Control word fields.
    localparam int USS_CTRL_PHY_SUSPEND = 0;
    localparam int USS_CTRL_WAKE_EN = 1;
    localparam int USS_CTRL_REMOTE_WKUP = 2;
    localparam int USS_CTRL_SOFT_RESET = 3;
    localparam int USS_CTRL_READY_CMD = 4;

    // Status word fields; bits 2 to 5 are cleared by writing 1.
    localparam int USS_STAT_SUSPEND_N = 0;
    localparam int USS_STAT_VBUS = 1;
    localparam int USS_STAT_WAKE = 2;
    localparam int USS_STAT_SUSP_EVT = 3;
    localparam int USS_STAT_PWR_EVT = 4;
    localparam int USS_STAT_RST_EVT = 5;

    // Device word fields: address and the three-bit state field.
    localparam int USS_DEV_ADDR_LSB = 0;
    localparam int USS_DEV_STATE_LSB = 8;
    localparam logic [2:0] USS_FIELD_DEFAULT = 3'h1;
    localparam logic [2:0] USS_FIELD_ADDRESSED = 3'h2;
    localparam logic [2:0] USS_FIELD_CONFIGURED = 3'h4;

    // Interrupt enable word fields.
    localparam int USS_IEN_PWR = 0;
    localparam int USS_IEN_SUSP = 1;

    // Synchroniser lanes.
    localparam int USS_SYN_SUSP = 0;
    localparam int USS_SYN_VBUS = 1;
    localparam int USS_SYN_BRST = 2;
    localparam int USS_SYN_UCLK = 3;
    localparam int USS_SYN_W = 4;

    localparam logic [6:0] USS_ADDR_RESET = 7'h00;

    typedef enum logic [2:0] {
        USS_DISCONNECTED,
        USS_ATTACHED,
        USS_DEFAULT,
        USS_ADDRESSED,
        USS_CONFIGURED
    } uss_dev_state_t;

endpackage : uss_pkg

// ### core/uss_suspend_ctrl.sv
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Function
// - Bus suspend drops suspend status and raises the suspend/resume interrupt.
// - Suspend leaves running master transfers alone until software aborts them.
// - Writing 1 to the PHY suspend bit drives the PHY sleep output low.
// - Resume with wake enabled pulls the wake output low with no clock.
// - When the clock returns after wake, PHY sleep output releases and its bit clears.
// - Clearing the wake factor and wake enable releases the wake output.
// - Resume with clock running raises suspend status, releases PHY, raises interrupt.
// - VBUS loss while suspended with wake enabled pulls the wake output low.
// - After disconnect, clearing PHY suspend and wake bits releases both outputs.
// - Remote wakeup bit signals wakeup on the bus and raises suspend status.
// - Suspend status returning high raises the interrupt and releases the PHY.
// - Remote wakeup bit clears itself once the USB clock runs again.
// - Hardware reset leaves the device Disconnected with every endpoint invalid.
// - Ready command selects full speed and enables the D+ pull-up.
// - After ready and before bus reset, only bus reset is answered.
// - Bus reset enters Default where only endpoint 0 is ready.
// - Addressed state rejects every endpoint except endpoint 0.
module uss_suspend_ctrl
    import uss_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic bus_suspend_n_in,
    input wire logic vbus_sense_in,
    input wire logic bus_reset_in,
    input wire logic usb_clk_run_in,
    input wire logic host_token_valid,
    input wire logic [3:0] host_token_ep,
    output logic token_accept,
    output logic phy_sleep_n_out,
    output logic wake_n_out,
    output logic remote_wake_out,
    output logic dplus_pullup_out,
    output logic full_speed_out,
    output logic soft_power_reset,
    output logic usb_device_irq
);

    typedef struct packed {
        logic [USS_SYN_W-1:0] s1;
        logic [USS_SYN_W-1:0] s2;
        logic [USS_SYN_W-1:0] s3;
        logic [USS_SYN_W-1:0] filt;
        logic phy_suspend;
        logic wake_en;
        logic remote_wkup;
        logic soft_reset;
        logic wake_flag;
        logic susp_evt;
        logic pwr_evt;
        logic rst_evt;
        logic en_pwr;
        logic en_susp;
        logic [6:0] dev_addr;
        uss_dev_state_t dev_state;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } uss_state_t;

    uss_state_t state_reg;
    uss_state_t state_next;

    logic bus_wr;
    logic susp_rise;
    logic susp_fall;
    logic vbus_chg;
    logic brst_rise;
    logic uclk_rise;
    logic [2:0] field_w;

    assign bus_wr = avs_write && state_reg.ack;
    assign field_w = avs_writedata[USS_DEV_STATE_LSB +: 3];

    always_comb begin
        state_next = state_reg;
        // Remote wakeup forces suspend status high ahead of the synchroniser.
        state_next.s1 = {usb_clk_run_in, bus_reset_in, vbus_sense_in,
                         bus_suspend_n_in | state_reg.remote_wkup};
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        // A lane moves only once the second and third stages agree.
        state_next.filt = (state_reg.s2 & state_reg.s3)
                        | (state_reg.filt & (state_reg.s2 ^ state_reg.s3));
        susp_rise = state_next.filt[USS_SYN_SUSP] && !state_reg.filt[USS_SYN_SUSP];
        susp_fall = !state_next.filt[USS_SYN_SUSP] && state_reg.filt[USS_SYN_SUSP];
        vbus_chg = state_next.filt[USS_SYN_VBUS] != state_reg.filt[USS_SYN_VBUS];
        brst_rise = state_next.filt[USS_SYN_BRST] && !state_reg.filt[USS_SYN_BRST];
        uclk_rise = state_next.filt[USS_SYN_UCLK] && !state_reg.filt[USS_SYN_UCLK];

        // One wait state: the answer comes in the cycle after the request.
        state_next.ack = (avs_read || avs_write) && !state_reg.ack;
        if ((avs_read || avs_write) && !state_reg.ack) begin
            case (avs_address)
                USS_ADDR_CTRL: state_next.rdata = {27'h0000000, 1'b0,
                    state_reg.soft_reset, state_reg.remote_wkup,
                    state_reg.wake_en, state_reg.phy_suspend};
                USS_ADDR_STAT: state_next.rdata = {26'h0000000,
                    state_reg.rst_evt, state_reg.pwr_evt, state_reg.susp_evt,
                    state_reg.wake_flag, state_reg.filt[USS_SYN_VBUS],
                    state_reg.filt[USS_SYN_SUSP]};
                USS_ADDR_DEV: begin
                    state_next.rdata = 32'h00000000;
                    state_next.rdata[USS_DEV_ADDR_LSB +: 7] = state_reg.dev_addr;
                    case (state_reg.dev_state)
                        USS_DEFAULT: state_next.rdata[USS_DEV_STATE_LSB +: 3] = USS_FIELD_DEFAULT;
                        USS_ADDRESSED: state_next.rdata[USS_DEV_STATE_LSB +: 3] = USS_FIELD_ADDRESSED;
                        USS_CONFIGURED: state_next.rdata[USS_DEV_STATE_LSB +: 3] = USS_FIELD_CONFIGURED;
                        default: state_next.rdata[USS_DEV_STATE_LSB +: 3] = 3'h0;
                    endcase
                end
                USS_ADDR_IEN: state_next.rdata = {30'h00000000, state_reg.en_susp,
                    state_reg.en_pwr};
                default: state_next.rdata = 32'h00000000;
            endcase
        end

        // Software writes take effect first so that hardware sets below win.
        if (bus_wr) begin
            case (avs_address)
                USS_ADDR_CTRL: begin
                    state_next.phy_suspend = avs_writedata[USS_CTRL_PHY_SUSPEND];
                    state_next.wake_en = avs_writedata[USS_CTRL_WAKE_EN];
                    state_next.remote_wkup = avs_writedata[USS_CTRL_REMOTE_WKUP];
                    state_next.soft_reset = avs_writedata[USS_CTRL_SOFT_RESET];
                    if (avs_writedata[USS_CTRL_READY_CMD]
                        && state_reg.dev_state == USS_DISCONNECTED) begin
                        state_next.dev_state = USS_ATTACHED;
                    end
                end
                USS_ADDR_STAT: begin
                    if (avs_writedata[USS_STAT_WAKE]) state_next.wake_flag = 1'b0;
                    if (avs_writedata[USS_STAT_SUSP_EVT]) state_next.susp_evt = 1'b0;
                    if (avs_writedata[USS_STAT_PWR_EVT]) state_next.pwr_evt = 1'b0;
                    if (avs_writedata[USS_STAT_RST_EVT]) state_next.rst_evt = 1'b0;
                end
                USS_ADDR_DEV: begin
                    if (state_reg.dev_state != USS_DISCONNECTED
                        && state_reg.dev_state != USS_ATTACHED) begin
                        state_next.dev_addr = avs_writedata[USS_DEV_ADDR_LSB +: 7];
                        case (field_w)
                            USS_FIELD_DEFAULT: state_next.dev_state = USS_DEFAULT;
                            USS_FIELD_ADDRESSED: state_next.dev_state = USS_ADDRESSED;
                            USS_FIELD_CONFIGURED: state_next.dev_state = USS_CONFIGURED;
                            default: state_next.dev_state = state_reg.dev_state;
                        endcase
                    end
                end
                USS_ADDR_IEN: begin
                    state_next.en_pwr = avs_writedata[USS_IEN_PWR];
                    state_next.en_susp = avs_writedata[USS_IEN_SUSP];
                end
                default: begin
                end
            endcase
        end

        // Suspend only flags software; master transfers are not touched here.
        if (susp_rise || susp_fall) begin
            state_next.susp_evt = 1'b1;
        end
        // Resume, local or remote, brings the PHY out of sleep.
        if (susp_rise) begin
            state_next.phy_suspend = 1'b0;
        end
        if (vbus_chg) begin
            state_next.pwr_evt = 1'b1;
        end
        // The wake factor is latched so wake stays asserted until software clears it.
        if (state_reg.wake_en && (state_reg.filt[USS_SYN_SUSP]
            || !state_reg.filt[USS_SYN_VBUS])) begin
            state_next.wake_flag = 1'b1;
        end
        if (uclk_rise) begin
            state_next.remote_wkup = 1'b0;
        end
        if (brst_rise && state_reg.dev_state != USS_DISCONNECTED) begin
            state_next.rst_evt = 1'b1;
            state_next.dev_state = USS_DEFAULT;
            state_next.dev_addr = USS_ADDR_RESET;
        end
        if (state_reg.soft_reset) begin
            state_next.dev_state = USS_DISCONNECTED;
            state_next.dev_addr = USS_ADDR_RESET;
        end
        state_next.irq = (state_next.susp_evt && state_next.en_susp)
                       || (state_next.pwr_evt && state_next.en_pwr);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
            state_reg.dev_state <= USS_DISCONNECTED;
            state_reg.filt <= 4'h3;
            // The stages start at the idle levels of their lanes, so no false edge follows reset.
            state_reg.s1 <= 4'h3;
            state_reg.s2 <= 4'h3;
            state_reg.s3 <= 4'h3;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        case (state_reg.dev_state)
            USS_DEFAULT: token_accept = host_token_valid && host_token_ep == 4'h0;
            USS_ADDRESSED: token_accept = host_token_valid && host_token_ep == 4'h0;
            USS_CONFIGURED: token_accept = host_token_valid;
            default: token_accept = 1'b0;
        endcase
    end

    assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
    assign avs_readdata = state_reg.rdata;
    assign phy_sleep_n_out = !state_reg.phy_suspend;
    // Built from raw pins so it works while the core clock is stopped.
    assign wake_n_out = !(state_reg.wake_en && (state_reg.wake_flag
                        || bus_suspend_n_in || !vbus_sense_in));
    assign remote_wake_out = state_reg.remote_wkup;
    assign dplus_pullup_out = state_reg.dev_state != USS_DISCONNECTED;
    assign full_speed_out = state_reg.dev_state != USS_DISCONNECTED;
    assign soft_power_reset = state_reg.soft_reset;
    assign usb_device_irq = state_reg.irq;

    a_susp_evt_set: assert property (@(posedge clock) disable iff (!nrst)
        (susp_rise || susp_fall) |=> state_reg.susp_evt)
        else $error("suspend change did not set the event flag");
    a_phy_sleep_set: assert property (@(posedge clock) disable iff (!nrst)
        bus_wr && avs_address == USS_ADDR_CTRL && avs_writedata[0] && !susp_rise
        |=> !phy_sleep_n_out)
        else $error("phy sleep output not asserted after write");
    a_wake_on_resume: assert property (@(posedge clock) disable iff (!nrst)
        state_reg.wake_en && bus_suspend_n_in |-> !wake_n_out)
        else $error("wake output not low on resume");
    a_wake_on_vbus: assert property (@(posedge clock) disable iff (!nrst)
        state_reg.wake_en && !vbus_sense_in |-> !wake_n_out)
        else $error("wake output not low on vbus loss");
    a_wake_released: assert property (@(posedge clock) disable iff (!nrst)
        !state_reg.wake_en |-> wake_n_out)
        else $error("wake output low without wake enable");
    a_resume_phy_up: assert property (@(posedge clock) disable iff (!nrst)
        susp_rise |=> phy_sleep_n_out && state_reg.susp_evt)
        else $error("resume did not release phy sleep");
    a_remote_clear: assert property (@(posedge clock) disable iff (!nrst)
        uclk_rise |=> !remote_wake_out)
        else $error("remote wakeup bit not cleared");
    a_bus_reset_dflt: assert property (@(posedge clock) disable iff (!nrst)
        brst_rise && state_reg.dev_state != USS_DISCONNECTED && !state_reg.soft_reset
        |=> state_reg.dev_state == USS_DEFAULT)
        else $error("bus reset did not enter default");
    a_ready_silent: assert property (@(posedge clock) disable iff (!nrst)
        state_reg.dev_state == USS_ATTACHED |-> !token_accept)
        else $error("token accepted before bus reset");
    a_addr_ep0_only: assert property (@(posedge clock) disable iff (!nrst)
        state_reg.dev_state == USS_ADDRESSED && host_token_ep != 4'h0 |-> !token_accept)
        else $error("addressed state accepted non-zero endpoint");
    a_sync_latency: assert property (@(posedge clock) disable iff (!nrst)
        $rose(bus_suspend_n_in) && !state_reg.remote_wkup ##1 bus_suspend_n_in [*4]
        |-> state_reg.filt[USS_SYN_SUSP])
        else $error("suspend status not synchronised in time");
    a_bus_one_wait: assert property (@(posedge clock) disable iff (!nrst)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held more than one cycle");


    // Remote wakeup bypasses the pin, yet still passes all three stages.
    a_remote_status: assert property (@(posedge clock) disable iff (!nrst)
        $rose(state_reg.remote_wkup) ##1 state_reg.remote_wkup [*3]
        |=> state_reg.filt[USS_SYN_SUSP])
        else $error("remote wakeup did not raise suspend status");
    a_remote_out: assert property (@(posedge clock) disable iff (!nrst)
        bus_wr && avs_address == USS_ADDR_CTRL && avs_writedata[USS_CTRL_REMOTE_WKUP]
        && !uclk_rise |=> remote_wake_out)
        else $error("remote wakeup request not driven");
    a_status_up_phy: assert property (@(posedge clock) disable iff (!nrst)
        $rose(state_reg.filt[USS_SYN_SUSP]) |-> phy_sleep_n_out && state_reg.susp_evt)
        else $error("status rise did not release phy or flag event");

    // The interrupt is a registered copy of the enabled flags.
    a_irq_enabled: assert property (@(posedge clock) disable iff (!nrst)
        state_reg.susp_evt && state_reg.en_susp |-> usb_device_irq)
        else $error("enabled suspend event without interrupt");
    a_irq_quiet: assert property (@(posedge clock) disable iff (!nrst)
        !state_reg.susp_evt && !state_reg.pwr_evt |-> !usb_device_irq)
        else $error("interrupt without any event flag");
    a_vbus_event: assert property (@(posedge clock) disable iff (!nrst)
        vbus_chg |=> state_reg.pwr_evt)
        else $error("vbus change did not set the power event");

    a_phy_release_wr: assert property (@(posedge clock) disable iff (!nrst)
        bus_wr && avs_address == USS_ADDR_CTRL && !avs_writedata[USS_CTRL_PHY_SUSPEND]
        |=> phy_sleep_n_out)
        else $error("phy sleep output held after clear");
    a_wake_factor: assert property (@(posedge clock) disable iff (!nrst)
        state_reg.wake_flag && state_reg.wake_en |-> !wake_n_out)
        else $error("latched wake factor not driving wake output");

    // Device state checks; a soft reset overrides every other move.
    a_ready_attach: assert property (@(posedge clock) disable iff (!nrst)
        bus_wr && avs_address == USS_ADDR_CTRL && avs_writedata[USS_CTRL_READY_CMD]
        && state_reg.dev_state == USS_DISCONNECTED && !state_reg.soft_reset
        |=> dplus_pullup_out && full_speed_out)
        else $error("ready command did not connect");
    a_discon_silent: assert property (@(posedge clock) disable iff (!nrst)
        !dplus_pullup_out |-> !token_accept)
        else $error("token accepted while disconnected");
    a_addr_cleared: assert property (@(posedge clock) disable iff (!nrst)
        state_reg.dev_state == USS_DISCONNECTED || state_reg.dev_state == USS_ATTACHED
        |-> state_reg.dev_addr == USS_ADDR_RESET)
        else $error("address kept before bus reset");
    a_dflt_ep0: assert property (@(posedge clock) disable iff (!nrst)
        state_reg.dev_state == USS_DEFAULT && host_token_ep != 4'h0 |-> !token_accept)
        else $error("default state accepted non-zero endpoint");
    a_addr_write: assert property (@(posedge clock) disable iff (!nrst)
        bus_wr && avs_address == USS_ADDR_DEV && field_w == USS_FIELD_ADDRESSED
        && state_reg.dev_state != USS_DISCONNECTED && state_reg.dev_state != USS_ATTACHED
        && !brst_rise && !state_reg.soft_reset
        |=> state_reg.dev_state == USS_ADDRESSED)
        else $error("state field write did not enter addressed");

    c_suspend: cover property (@(posedge clock) disable iff (!nrst) susp_fall);
    c_vbus_wake: cover property (@(posedge clock) disable iff (!nrst)
        state_reg.wake_en && !vbus_sense_in && !wake_n_out);
    c_resume_wake: cover property (@(posedge clock) disable iff (!nrst)
        state_reg.wake_en && !wake_n_out);
    c_addressed: cover property (@(posedge clock) disable iff (!nrst)
        state_reg.dev_state == USS_ADDRESSED);
    c_remote: cover property (@(posedge clock) disable iff (!nrst) uclk_rise);

endmodule : uss_suspend_ctrl

// ### tb/uss_phy_host_model.sv
`timescale 1ns/1ps
module uss_phy_host_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic bus_idle,
    input wire logic pwr_on,
    input wire logic rst_req,
    input wire logic tok_req,
    input wire logic [3:0] tok_ep,
    input wire logic phy_sleep_n_out,
    input wire logic remote_wake_out,
    output logic bus_suspend_n_in,
    output logic vbus_sense_in,
    output logic bus_reset_in,
    output logic usb_clk_run_in,
    output logic host_token_valid,
    output logic [3:0] host_token_ep
);
    logic [3:0] last_ep;
    // The host answers a remote wakeup request by driving resume on the bus itself.
    assign bus_suspend_n_in = !bus_idle || remote_wake_out;
    assign vbus_sense_in = pwr_on;
    // No bus reset or token is signalled on an unpowered bus.
    assign bus_reset_in = rst_req && pwr_on;
    assign host_token_valid = tok_req && pwr_on && !bus_idle;
    // Between tokens the endpoint lines never repeat the last number.
    assign host_token_ep = tok_req ? tok_ep : ~last_ep;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            last_ep <= 4'h0;
            usb_clk_run_in <= 1'h0;
        end else begin
            if (tok_req) begin
                last_ep <= tok_ep;
            end
            // The PHY clock only restarts a cycle after sleep is released.
            usb_clk_run_in <= phy_sleep_n_out;
        end
    end
endmodule : uss_phy_host_model

// ### tb/tb_usb_device_suspend_resume_state.sv
`timescale 1ns/1ps
module tb_usb_device_suspend_resume_state;
    import uss_pkg::*;
    typedef struct {logic wr; logic [3:0] a; logic [31:0] d; logic [31:0] e;} uss_row_t;
    logic clock = 1'h0;
    logic nrst = 1'h0;
    logic clk_en = 1'h1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, bus_suspend_n_in, vbus_sense_in, bus_reset_in, usb_clk_run_in;
    logic host_token_valid, token_accept, phy_sleep_n_out, wake_n_out, remote_wake_out;
    logic dplus_pullup_out, full_speed_out, soft_power_reset, usb_device_irq;
    logic [3:0] host_token_ep;
    logic bus_idle = 1'h0;
    logic pwr_on = 1'h1;
    logic rst_req = 1'h0;
    logic tok_req = 1'h0;
    logic [3:0] tok_ep = 4'h0;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    // Reset values, an unmapped word and a device write refused while disconnected.
    uss_row_t rows [10] = '{'{1'h0, USS_ADDR_CTRL, 32'h0, 32'h0},
        '{1'h0, USS_ADDR_STAT, 32'h0, 32'h3}, '{1'h0, USS_ADDR_DEV, 32'h0, 32'h0},
        '{1'h0, USS_ADDR_IEN, 32'h0, 32'h0}, '{1'h1, 4'h2, 32'hFFFFFFFF, 32'h0},
        '{1'h0, 4'h2, 32'h0, 32'h0}, '{1'h1, USS_ADDR_DEV, 32'h12A, 32'h0},
        '{1'h0, USS_ADDR_DEV, 32'h0, 32'h0}, '{1'h1, USS_ADDR_IEN, 32'h3, 32'h0},
        '{1'h0, USS_ADDR_IEN, 32'h0, 32'h3}};
    uss_suspend_ctrl DUT (.clock, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .bus_suspend_n_in, .vbus_sense_in, .bus_reset_in,
        .usb_clk_run_in, .host_token_valid, .host_token_ep, .token_accept, .phy_sleep_n_out,
        .wake_n_out, .remote_wake_out, .dplus_pullup_out, .full_speed_out, .soft_power_reset,
        .usb_device_irq);
    uss_phy_host_model host (.clock, .nrst, .bus_idle, .pwr_on, .rst_req, .tok_req, .tok_ep,
        .phy_sleep_n_out, .remote_wake_out, .bus_suspend_n_in, .vbus_sense_in, .bus_reset_in,
        .usb_clk_run_in, .host_token_valid, .host_token_ep);
    // Clearing the enable freezes the core clock, as in the low-power mode.
    initial begin
        forever begin
            #20;
            if (clk_en) clock = ~clock;
        end
    end
    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk
    // The request stands until the rising edge that samples waitrequest low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 50);
        if (n >= 50) fails++;
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask : wr
    task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        chk(nm, q, e);
    endtask : rc
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : settle
    task automatic tokc(input string nm, input logic [3:0] ep, input logic e);
        @(posedge clock);
        tok_req <= 1'h1;
        tok_ep <= ep;
        @(negedge clock);
        chk(nm, token_accept, e);
        @(posedge clock);
        tok_req <= 1'h0;
    endtask : tokc
    // Bus goes quiet, the event is cleared and the PHY put to sleep.
    task automatic suspend(input logic [31:0] ctrl, input logic [31:0] ien);
        @(posedge clock);
        bus_idle <= 1'h1;
        settle(8);
        wr(USS_ADDR_STAT, 32'h8);
        wr(USS_ADDR_CTRL, ctrl);
        wr(USS_ADDR_IEN, ien);
    endtask : suspend
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else rc("row", rows[i].a, rows[i].e);
        end
        $display("register table done");
        wr(USS_ADDR_CTRL, 32'h10);
        settle(1);
        chk("pullup", dplus_pullup_out, 1);
        chk("full_speed", full_speed_out, 1);
        tokc("tok_attached", 4'h0, 1'h0);
        @(posedge clock);
        rst_req <= 1'h1;
        settle(8);
        @(posedge clock);
        rst_req <= 1'h0;
        settle(8);
        rc("dev_default", USS_ADDR_DEV, 32'h100);
        rc("stat_reset", USS_ADDR_STAT, 32'h23);
        wr(USS_ADDR_STAT, 32'h20);
        tokc("tok_def_ep0", 4'h0, 1'h1);
        tokc("tok_def_ep1", 4'h1, 1'h0);
        wr(USS_ADDR_DEV, 32'h22A);
        rc("dev_addressed", USS_ADDR_DEV, 32'h22A);
        tokc("tok_adr_ep0", 4'h0, 1'h1);
        tokc("tok_adr_ep3", 4'h3, 1'h0);
        wr(USS_ADDR_DEV, 32'h42A);
        tokc("tok_cfg_ep3", 4'h3, 1'h1);
        $display("device states done");
        @(posedge clock);
        bus_idle <= 1'h1;
        settle(8);
        rc("stat_susp", USS_ADDR_STAT, 32'hA);
        chk("irq_susp", usb_device_irq, 1);
        suspend(32'h1, 32'h3);
        chk("phy_sleep", phy_sleep_n_out, 0);
        chk("irq_clear", usb_device_irq, 0);
        @(posedge clock);
        bus_idle <= 1'h0;
        settle(8);
        chk("phy_resume", phy_sleep_n_out, 1);
        chk("irq_resume", usb_device_irq, 1);
        rc("stat_resume", USS_ADDR_STAT, 32'hB);
        suspend(32'h3, 32'h0);
        chk("wake_idle", wake_n_out, 1);
        @(posedge clock);
        bus_idle <= 1'h0;
        clk_en = 1'h0;
        #100;
        chk("wake_resume", wake_n_out, 0);
        clk_en = 1'h1;
        settle(8);
        chk("phy_clock_back", phy_sleep_n_out, 1);
        rc("ctrl_clock_back", USS_ADDR_CTRL, 32'h2);
        rc("stat_wake", USS_ADDR_STAT, 32'hF);
        wr(USS_ADDR_STAT, 32'hC);
        wr(USS_ADDR_CTRL, 32'h0);
        settle(1);
        chk("wake_release", wake_n_out, 1);
        wr(USS_ADDR_IEN, 32'h3);
        suspend(32'h3, 32'h0);
        @(posedge clock);
        pwr_on <= 1'h0;
        clk_en = 1'h0;
        #100;
        chk("wake_vbus", wake_n_out, 0);
        clk_en = 1'h1;
        settle(8);
        rc("stat_vbus", USS_ADDR_STAT, 32'h14);
        chk("phy_held", phy_sleep_n_out, 0);
        wr(USS_ADDR_CTRL, 32'h0);
        settle(1);
        chk("phy_disc", phy_sleep_n_out, 1);
        chk("wake_disc", wake_n_out, 1);
        wr(USS_ADDR_CTRL, 32'h8);
        settle(1);
        chk("soft_reset", soft_power_reset, 1);
        chk("pullup_off", dplus_pullup_out, 0);
        wr(USS_ADDR_CTRL, 32'h0);
        pwr_on <= 1'h1;
        suspend(32'h1, 32'h3);
        wr(USS_ADDR_STAT, 32'h3C);
        wr(USS_ADDR_CTRL, 32'h5);
        settle(1);
        chk("remote_out", remote_wake_out, 1);
        settle(8);
        rc("stat_remote", USS_ADDR_STAT, 32'hB);
        chk("phy_remote", phy_sleep_n_out, 1);
        chk("irq_remote", usb_device_irq, 1);
        rc("ctrl_remote", USS_ADDR_CTRL, 32'h0);
        chk("remote_clear", remote_wake_out, 0);
        @(posedge clock);
        bus_idle <= 1'h0;
        nrst <= 1'h0;
        repeat (2) @(posedge clock);
        nrst <= 1'h1;
        rc("ctrl_rearm", USS_ADDR_CTRL, 32'h0);
        chk("irq_rearm", usb_device_irq, 0);
        $display("suspend and wake done");
        conclude();
    end
endmodule : tb_usb_device_suspend_resume_state
